/* File: core/icss_top.sv */
// top: register slave, channel selection, scan and test-level substitution
// Function
// [RULE1] selection comes from bits 3 to 7 of control register 0
// [RULE2] in single-channel mode bits 3 and 4 pick the input or pair
// [RULE3] bit 5 picks single-ended or differential input
// [RULE4] bits 6 and 7 pick an autoscan list over several inputs
// [RULE5] plain single-ended codes 0..3 pick A pos, A neg, B pos, B neg
// [RULE6] differential codes 0 and 1 pick pair A and pair B
// [RULE7] scan code 1 alternates A pos and A neg
// [RULE8] scan code 2 cycles A pos, A neg, B pos
// [RULE9] scan code 3 cycles A pos, A neg, B pos, B neg
// [RULE10] scan with one pair, code 1, alternates A pos and pair B
// [RULE11] scan with one pair, code 2, cycles A pos, A neg, pair B
// [RULE12] scan with two pairs alternates pair A and pair B
// [RULE13] host writes only the twelve valid selection codes; the testbench also writes reserved code 06, which the sequencer parks
// [RULE14] scan advances one entry per conversion and wraps at the end
// [RULE15] test selection comes from bits 8 and 9
// [RULE16] test 00 normal, 01 upper, 10 midpoint, 11 lower reference level
// [RULE17] host reaches control register 0 at address zero
// [RULE18] control register 0 is write-only and reads back as zero
`timescale 1ns/1ns
`default_nettype none
module icss_top
    import icss_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_done,
    input wire logic [CODE_W-1:0] adc_code,
    output var icss_chan_t input_select,
    output logic [CODE_W-1:0] result_code,
    output var icss_chan_t result_chan,
    output logic result_valid
);

    // write and read channel holding registers
    logic aw_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_full_reg;
    logic [DATA_W-1:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [DATA_W-1:0] rdata_reg;

    // block state
    logic [CTRL0_W-1:0] ctrl0_reg;
    logic [CTRL0_W-1:0] ctrl0_next;
    logic [CODE_W-1:0] code_reg;
    icss_chan_t rchan_reg;
    logic rvalid_out_reg;

    wire logic aw_fire;
    wire logic w_fire;
    wire logic wr_go;
    wire logic ar_fire;
    wire logic wr_ctrl0;
    wire logic wr_mapped;
    wire logic [CFG_W-1:0] cfg;
    wire logic [TEST_W-1:0] test_sel;
    wire logic [1:0] slot;
    wire logic reserved;
    wire logic scanning;
    icss_chan_t cur_chan;
    wire logic [DATA_W-1:0] status_word;
    wire logic [DATA_W-1:0] result_word;
    wire logic [DATA_W-1:0] rd_word;
    wire logic [1:0] rd_resp;
    wire logic [CODE_W-1:0] code_sel;

    // address and data are taken in either order, then one response
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !w_full_reg && !bvalid_reg;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (aw_fire) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else if (w_fire) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_go) begin
            w_full_reg <= 1'b0;
        end
    end

    // control register 0 sits at offset zero, as on the parallel port
    assign wr_ctrl0 = wr_go && (aw_addr_reg[ADDR_W-1:2] == OFS_CTRL0[ADDR_W-1:2]); // [RULE17]
    assign wr_mapped = (aw_addr_reg[ADDR_W-1:2] == OFS_CTRL0[ADDR_W-1:2])
        || (aw_addr_reg[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2])
        || (aw_addr_reg[ADDR_W-1:2] == OFS_RESULT[ADDR_W-1:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // byte lanes 0 and 1 carry the ten control bits
    always_comb begin
        ctrl0_next = ctrl0_reg;
        if (w_strb_reg[0]) begin
            ctrl0_next[7:0] = w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
            ctrl0_next[CTRL0_W-1:8] = w_data_reg[CTRL0_W-1:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_reg <= CTRL0_RESET;
        end else if (wr_ctrl0) begin
            ctrl0_reg <= ctrl0_next;
        end
    end

    // reserved codes are not trapped; the sequencer parks and status flags them
    assign cfg = ctrl0_reg[CFG_LSB +: CFG_W]; // [RULE1] [RULE13]
    assign test_sel = ctrl0_reg[TEST_LSB +: TEST_W]; // [RULE15]

    icss_scan_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .restart(wr_ctrl0),
        .advance(conv_done),
        .chan(cur_chan),
        .slot(slot),
        .reserved(reserved),
        .scanning(scanning)
    );

    assign input_select = cur_chan; // [RULE2] [RULE3]

    // test levels replace the code but keep the channel tag
    assign code_sel = (test_sel == TEST_UPPER) ? LEVEL_UPPER
        : (test_sel == TEST_MID) ? LEVEL_MID
        : (test_sel == TEST_LOWER) ? LEVEL_LOWER
        : adc_code; // [RULE16]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_reg <= '0;
            rchan_reg <= CH_A_POS;
            rvalid_out_reg <= 1'b0;
        end else begin
            rvalid_out_reg <= conv_done;
            if (conv_done) begin
                code_reg <= code_sel;
                rchan_reg <= cur_chan;
            end
        end
    end

    assign result_code = code_reg;
    assign result_chan = rchan_reg;
    assign result_valid = rvalid_out_reg;

    // read side
    assign status_word = {25'h0, scanning, reserved, slot, 3'(cur_chan)};
    assign result_word = {19'h0, 3'(rchan_reg), code_reg};
    assign rd_word = (s_axi_araddr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2]) ? status_word
        : (s_axi_araddr[ADDR_W-1:2] == OFS_RESULT[ADDR_W-1:2]) ? result_word
        : 32'h0; // [RULE18]
    assign rd_resp = ((s_axi_araddr[ADDR_W-1:2] == OFS_CTRL0[ADDR_W-1:2])
        || (s_axi_araddr[ADDR_W-1:2] == OFS_STATUS[ADDR_W-1:2])
        || (s_axi_araddr[ADDR_W-1:2] == OFS_RESULT[ADDR_W-1:2])) ? RESP_OKAY : RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // checks
    wire logic step = conv_done && !wr_ctrl0;

    property p_cfg_load;
        @(posedge aclk) disable iff (!aresetn)
        (wr_ctrl0 && (w_strb_reg[1:0] == 2'h3)) |=> (cfg == $past(w_data_reg[7:3]));
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("selection field not loaded"); // [RULE1]

    // input_select trails a control write by one cycle, hence the stable guards
    property p_single_ended;
        @(posedge aclk) disable iff (!aresetn)
        (cfg[4:2] == 3'h0 && $stable(cfg)) |-> (3'(input_select) == {1'b0, cfg[1:0]});
    endproperty
    a_single_ended: assert property (p_single_ended) else $error("single-ended pick wrong"); // [RULE5]

    property p_diff_pair;
        @(posedge aclk) disable iff (!aresetn)
        (cfg[4:1] == 4'h2 && $stable(cfg)) |-> (input_select == (cfg[0] ? CH_DIFF_B : CH_DIFF_A));
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("differential pick wrong"); // [RULE6]

    property p_scan_two;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h11 && $stable(cfg) && input_select == CH_A_NEG && step)
            |=> (input_select == CH_A_POS);
    endproperty
    a_scan_two: assert property (p_scan_two) else $error("two-input scan broken"); // [RULE7]

    property p_scan_three;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h12 && $stable(cfg) && input_select == CH_A_NEG && step) |=> (input_select == CH_B_POS);
    endproperty
    a_scan_three: assert property (p_scan_three) else $error("three-input scan broken"); // [RULE8]

    property p_scan_four;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h13 && $stable(cfg) && input_select == CH_B_NEG && step) |=> (input_select == CH_A_POS);
    endproperty
    a_scan_four: assert property (p_scan_four) else $error("four-input scan wrap broken"); // [RULE9]

    property p_scan_mix2;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h15 && $stable(cfg) && input_select == CH_A_POS && step) |=> (input_select == CH_DIFF_B);
    endproperty
    a_scan_mix2: assert property (p_scan_mix2) else $error("mixed two scan broken"); // [RULE10]

    property p_scan_mix3;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h16 && $stable(cfg) && input_select == CH_DIFF_B && step) |=> (input_select == CH_A_POS);
    endproperty
    a_scan_mix3: assert property (p_scan_mix3) else $error("mixed three scan broken"); // [RULE11]

    property p_scan_pairs;
        @(posedge aclk) disable iff (!aresetn)
        (cfg == 5'h19 && $stable(cfg) && input_select == CH_DIFF_A && step) |=> (input_select == CH_DIFF_B);
    endproperty
    a_scan_pairs: assert property (p_scan_pairs) else $error("pair scan broken"); // [RULE12]

    property p_hold_between;
        @(posedge aclk) disable iff (!aresetn)
        (!conv_done && !wr_ctrl0 && $stable(cfg)) |=> $stable(input_select);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("channel moved without conversion"); // [RULE14]

    property p_test_level;
        @(posedge aclk) disable iff (!aresetn)
        (conv_done && test_sel != TEST_NORMAL) |=> result_valid
            && (result_code == (($past(test_sel) == TEST_UPPER) ? LEVEL_UPPER
                : ($past(test_sel) == TEST_MID) ? LEVEL_MID : LEVEL_LOWER));
    endproperty
    a_test_level: assert property (p_test_level) else $error("test level not substituted"); // [RULE16]

    property p_normal_pass;
        @(posedge aclk) disable iff (!aresetn)
        (conv_done && test_sel == TEST_NORMAL) |=> (result_code == $past(adc_code));
    endproperty
    a_normal_pass: assert property (p_normal_pass) else $error("normal code altered"); // [RULE16]

    property p_ctrl0_readback;
        @(posedge aclk) disable iff (!aresetn)
        (ar_fire && s_axi_araddr[ADDR_W-1:2] == OFS_CTRL0[ADDR_W-1:2])
            |=> (s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY);
    endproperty
    a_ctrl0_readback: assert property (p_ctrl0_readback) else $error("control register read not zero"); // [RULE18]

    property p_single_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!cfg[CFG_W-1] && $stable(cfg) && step) |=> $stable(input_select);
    endproperty
    a_single_hold: assert property (p_single_hold) else $error("single channel moved on conversion"); // [RULE2]

    property p_reserved_park;
        @(posedge aclk) disable iff (!aresetn)
        (reserved && $stable(cfg)) |-> (input_select == CH_A_POS && !scanning);
    endproperty
    a_reserved_park: assert property (p_reserved_park) else $error("reserved code not parked"); // [RULE13]

    property p_result_chan;
        @(posedge aclk) disable iff (!aresetn)
        conv_done |=> (result_valid && result_chan == $past(input_select));
    endproperty
    a_result_chan: assert property (p_result_chan) else $error("result tagged with wrong channel"); // [RULE14]

    property p_write_err;
        @(posedge aclk) disable iff (!aresetn)
        (wr_go && !wr_mapped) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    endproperty
    a_write_err: assert property (p_write_err) else $error("unmapped write not refused"); // [RULE17]

endmodule // icss_top
`default_nettype wire

/* File: core/icss_pkg.sv */
// package: constants, types and lookup functions for the input channel scan selector
package icss_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h08;

    // control register 0 layout
    localparam int CTRL0_W = 10;
    localparam logic [CTRL0_W-1:0] CTRL0_RESET = 10'h020;
    localparam int CFG_LSB = 3;
    localparam int CFG_W = 5;
    localparam int TEST_LSB = 8;
    localparam int TEST_W = 2;

    // status register layout
    localparam int STAT_CHAN_LSB = 0;
    localparam int STAT_SLOT_LSB = 3;
    localparam int STAT_RSVD_BIT = 5;
    localparam int STAT_SCAN_BIT = 6;

    // result register layout
    localparam int CODE_W = 10;
    localparam int RES_CHAN_LSB = 10;

    // test field values and substituted levels
    localparam logic [TEST_W-1:0] TEST_NORMAL = 2'h0;
    localparam logic [TEST_W-1:0] TEST_UPPER = 2'h1;
    localparam logic [TEST_W-1:0] TEST_MID = 2'h2;
    localparam logic [TEST_W-1:0] TEST_LOWER = 2'h3;
    localparam logic [CODE_W-1:0] LEVEL_UPPER = 10'h3FF;
    localparam logic [CODE_W-1:0] LEVEL_MID = 10'h200;
    localparam logic [CODE_W-1:0] LEVEL_LOWER = 10'h000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CH_A_POS, CH_A_NEG, CH_B_POS, CH_B_NEG, CH_DIFF_A, CH_DIFF_B
    } icss_chan_t;

    // length of the channel list for a selection code, zero when reserved
    function automatic logic [2:0] icss_list_len(input logic [CFG_W-1:0] cfg);
        logic [2:0] len;
        len = 3'h0;
        case (cfg)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: len = 3'h1;
            5'h11, 5'h15, 5'h19: len = 3'h2;
            5'h12, 5'h16: len = 3'h3;
            5'h13: len = 3'h4;
            default: len = 3'h0;
        endcase
        return len;
    endfunction

    // channel at a given position of the list for a selection code
    function automatic icss_chan_t icss_list_entry(input logic [CFG_W-1:0] cfg, input logic [1:0] slot);
        icss_chan_t ch;
        ch = CH_A_POS;
        case (cfg)
            5'h00, 5'h01, 5'h02, 5'h03: ch = icss_chan_t'({1'b0, cfg[1:0]}); // [RULE5]
            5'h04: ch = CH_DIFF_A; // [RULE6]
            5'h05: ch = CH_DIFF_B; // [RULE6]
            5'h11, 5'h12, 5'h13: ch = icss_chan_t'({1'b0, slot}); // [RULE7] [RULE8] [RULE9]
            5'h15: ch = (slot == 2'h0) ? CH_A_POS : CH_DIFF_B; // [RULE10]
            5'h16: ch = (slot == 2'h2) ? CH_DIFF_B : icss_chan_t'({1'b0, slot}); // [RULE11]
            5'h19: ch = (slot == 2'h0) ? CH_DIFF_A : CH_DIFF_B; // [RULE12]
            default: ch = CH_A_POS;
        endcase
        return ch;
    endfunction

endpackage

/* File: core/icss_scan_seq.sv */
// scan sequencer: walks the channel list of the current selection code
`timescale 1ns/1ns
`default_nettype none
module icss_scan_seq
    import icss_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CFG_W-1:0] cfg,
    input wire logic restart,
    input wire logic advance,
    output var icss_chan_t chan,
    output logic [1:0] slot,
    output logic reserved,
    output logic scanning
);

    logic [1:0] slot_reg;
    logic [1:0] slot_next;
    icss_chan_t chan_reg;
    icss_chan_t chan_next;
    wire logic [2:0] list_len;
    wire logic at_last;

    assign list_len = icss_list_len(cfg);
    assign at_last = ({1'b0, slot_reg} == (list_len - 3'h1));

    // a new selection always starts from the head of its list
    always_comb begin
        slot_next = slot_reg;
        if (restart) begin
            slot_next = 2'h0;
        end else if (advance && (list_len > 3'h1)) begin
            slot_next = at_last ? 2'h0 : slot_reg + 2'h1; // [RULE14]
        end
    end

    assign chan_next = icss_list_entry(cfg, slot_next); // [RULE4]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_reg <= 2'h0;
            chan_reg <= CH_DIFF_A;
        end else begin
            slot_reg <= slot_next;
            chan_reg <= chan_next;
        end
    end

    assign chan = chan_reg;
    assign slot = slot_reg;
    assign reserved = (list_len == 3'h0);
    assign scanning = cfg[CFG_W-1] && (list_len > 3'h1);

endmodule // icss_scan_seq
`default_nettype wire

/* File: verification/icss_host_model.sv */
// host model: axi4-lite master standing in for the processor that programs the selector
`timescale 1ns/1ns
`default_nettype none
module icss_host_model
    import icss_pkg::*;
(
    input wire logic aclk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // own copy of control register 0, it never reads back
    logic [CTRL0_W-1:0] ctrl0_shadow;

    initial begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        ctrl0_shadow = CTRL0_RESET;
    end

    // released payload is inverted so stale values cannot pass for live ones
    task automatic axi_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        // address bits 7 to 2 all low reach control register 0
        if (addr[ADDR_W-1:2] == '0)
            ctrl0_shadow = data[CTRL0_W-1:0];
    endtask

    task automatic axi_read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule // icss_host_model
`default_nettype wire

/* File: verification/testbench.sv */
// testbench: register writes, conversion pulses and result checks for the selector
`timescale 1ns/1ns
`default_nettype none
module testbench
    import icss_pkg::*;
;
    logic aclk;
    logic aresetn;
    logic conv_done;
    logic [CODE_W-1:0] adc_code;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    icss_chan_t input_select, result_chan;
    logic [CODE_W-1:0] result_code;
    logic result_valid;
    logic [DATA_W-1:0] rd;
    logic [1:0] rs;
    logic [31:0] exp_result;
    int num_errors = 0;
    int tests_run = 0;

    // valid selection codes only, lists packed 3 bits a slot, slot 0 lowest
    localparam logic [4:0] CFGS [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                         5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
    localparam int LENS [12] = '{1, 1, 1, 1, 1, 1, 2, 3, 4, 2, 3, 2};
    localparam logic [11:0] LISTS [12] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
                                           12'h008, 12'h088, 12'h688, 12'h028, 12'h148, 12'h02C};

    icss_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .conv_done, .adc_code, .input_select, .result_code, .result_chan, .result_valid);

    icss_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    function automatic icss_chan_t ent(input int i, input int k);
        return icss_chan_t'(LISTS[i][3*(k%LENS[i]) +: 3]);
    endfunction

    task automatic check_chan(input icss_chan_t got, input icss_chan_t exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: channel %0d, expected %0d", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: value %0h, expected %0h", $time, got, exp);
        end
    endtask

    // one conversion pulse, then result and following channel
    task automatic convert(input logic [CODE_W-1:0] code, input icss_chan_t chan, input icss_chan_t nxt,
                           input logic [CODE_W-1:0] exp_code);
        @(posedge aclk);
        conv_done <= 1'b1;
        adc_code <= code;
        @(posedge aclk);
        conv_done <= 1'b0;
        adc_code <= ~code;
        #1;
        check_word(32'(result_valid), 32'h1);
        check_chan(result_chan, chan);
        check_chan(input_select, nxt);
        check_word(32'(result_code), 32'(exp_code));
        exp_result = {19'h0, chan, exp_code};
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [CODE_W-1:0] lv [4];
        lv = '{10'h155, LEVEL_UPPER, LEVEL_MID, LEVEL_LOWER};
        aresetn = 1'b0;
        conv_done = 1'b0;
        adc_code = 10'h000;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check_chan(input_select, CH_DIFF_A);
        host.axi_read(OFS_CTRL0, rd, rs);
        check_word(rd, 32'h0);
        check_word(32'(rs), 32'(RESP_OKAY));
        for (int i = 0; i < 12; i++) begin
            host.axi_write(OFS_CTRL0, {24'h0, CFGS[i], 3'h0}, rs);
            #1;
            check_chan(input_select, ent(i, 0));
            for (int k = 0; k <= 2 * LENS[i]; k++)
                convert(10'(k * 37 + i), ent(i, k), ent(i, k + 1), 10'(k * 37 + i));
        end
        host.axi_read(OFS_RESULT, rd, rs);
        check_word(rd, exp_result);
        for (int t = 0; t < 4; t++) begin
            host.axi_write(OFS_CTRL0, {22'h0, 2'(t), 8'h00}, rs);
            convert(10'h155, CH_A_POS, CH_A_POS, lv[t]);
        end
        @(posedge aclk);
        #1;
        check_word(32'(result_valid), 32'h0);
        // a write mid-scan restarts the list at its first entry
        host.axi_write(OFS_CTRL0, {24'h0, 5'h13, 3'h0}, rs);
        convert(10'h011, CH_A_POS, CH_A_NEG, 10'h011);
        convert(10'h022, CH_A_NEG, CH_B_POS, 10'h022);
        // scanning, slot 2, on input b positive
        host.axi_read(OFS_STATUS, rd, rs);
        check_word(rd, 32'h52);
        // the register never reads back, so the host rewrites its own copy
        host.axi_write(OFS_CTRL0, {22'h0, host.ctrl0_shadow}, rs);
        #1;
        check_chan(input_select, CH_A_POS);
        // deliberate reserved code: parked on the first input, flagged
        host.axi_write(OFS_CTRL0, {24'h0, 5'h06, 3'h0}, rs);
        #1;
        check_chan(input_select, CH_A_POS);
        host.axi_read(OFS_STATUS, rd, rs);
        check_word(rd & 32'h67, 32'h20);
        host.axi_write(8'h10, 32'h0000_00FF, rs);
        check_word(32'(rs), 32'(RESP_SLVERR));
        host.axi_read(8'h10, rd, rs);
        check_word(rd, 32'h0);
        check_word(32'(rs), 32'(RESP_SLVERR));
        host.axi_write(OFS_RESULT, 32'hFFFF_FFFF, rs);
        check_word(32'(rs), 32'(RESP_OKAY));
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
